// File: pkg/rsc_regs.vh
// Purpose: Constants for the reset source controller.
// Assumes: 125 MHz system clock on clk_in.
// Notes:   Included by the reset source controller design files.
`ifndef RSC_REGS_VH
`define RSC_REGS_VH

`define RSC_CLK_MHZ        125
`define RSC_PIN_MIN_NS     10000
`define RSC_PIN_MIN_CYC    ((`RSC_PIN_MIN_NS * `RSC_CLK_MHZ + 999) / 1000)
`define RSC_VEC_LO_ADDR    16'h0000
`define RSC_VEC_HI_ADDR    16'h0001
`define RSC_ILLEGAL_OP     8'hff
`define RSC_NSRC           7
`define RSC_SRC_PIN        0
`define RSC_SRC_WDT        1
`define RSC_SRC_POR        2
`define RSC_SRC_LVD        3
`define RSC_SRC_ILL        4
`define RSC_SRC_PAR        5
`define RSC_SRC_IMA        6
`define RSC_PROC_CYC       16

`endif

// File: verilog/rsc_sync2.v
// Purpose: Two flip-flop synchroniser for one level.
// Assumes: Single clock clk_in.
// Notes:   Stage one is read only by stage two.
`timescale 1ns/1ps
module rsc_sync2 #(
   parameter RESET_VAL = 1'b0
) (
   // Clock and reset
   input  wire clk_in,
   input  wire rst_in,
   // Data
   input  wire d_in,
   output wire q_out
);
   reg s1_q;
   reg s2_q;

   always @(posedge clk_in) begin
      if (rst_in) begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
      end else begin
         s1_q <= d_in;
         s2_q <= s1_q;
      end
   end

   assign q_out = s2_q;
endmodule // rsc_sync2

// File: verilog/rsc_reset_ctrl.v
// Purpose: Combine seven reset sources into one system reset.
// Assumes: Sources asynchronous to clk_in; rst_in is power-up only.
// Notes:   Pin reset counts only after it has stood low 10 us.
`timescale 1ns/1ps
`include "rsc_regs.vh"
module rsc_reset_ctrl #(
   parameter PIN_MIN_CYC = `RSC_PIN_MIN_CYC,
   parameter PROC_CYC    = `RSC_PROC_CYC,
   parameter NPORT       = 8
) (
   // Clock and reset
   input  wire             clk_in,
   input  wire             rst_in,
   // Reset sources
   input  wire             reset_pin_n_in,
   input  wire             wdt_overflow_in,
   input  wire             por_detect_in,
   input  wire             lvd_detect_in,
   input  wire             parity_err_in,
   input  wire             illegal_access_in,
   // Instruction monitor
   input  wire             exec_valid_in,
   input  wire [7:0]       exec_opcode_in,
   input  wire             debug_mode_in,
   // Software control of the reset-output pin
   input  wire             rout_set_high_in,
   // External clock inputs
   input  wire             ext_main_clk_in,
   input  wire             ext_sub_clk_in,
   // System reset and per-unit resets
   output reg              sys_reset_out,
   output reg              wdt_reset_out,
   output reg              lvd_reset_out,
   output reg              sfr_init_out,
   output reg  [15:0]      vector_addr_out,
   output reg              vector_fetch_out,
   output reg  [`RSC_NSRC-1:0] cause_out,
   // Oscillator enables
   output reg              main_crystal_en_out,
   output reg              sub_crystal_en_out,
   output reg              fast_osc_en_out,
   output reg              slow_osc_en_out,
   output reg              clk_sel_fast_out,
   output reg              ext_main_clk_out,
   output reg              ext_sub_clk_out,
   // Port pins (enable low means driving)
   output reg              pullup_port_pin_pu_out,
   output reg              reset_out_port_pin_out,
   output reg              reset_out_port_pin_oe_n_out,
   output reg  [NPORT-1:0] port_oe_n_out
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   wire [5:0] raw_w;
   wire [5:0] syn_w;
   wire       pin_n_w;
   wire       dbg_w;

   assign raw_w = {illegal_access_in, parity_err_in, lvd_detect_in,
                   por_detect_in, wdt_overflow_in, debug_mode_in};

   rsc_sync2 #(.RESET_VAL(1'b0)) u_pin (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .d_in   (reset_pin_n_in),
      .q_out  (pin_n_w)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
         rsc_sync2 #(.RESET_VAL(1'b0)) u_s (
            .clk_in (clk_in),
            .rst_in (rst_in),
            .d_in   (raw_w[gi]),
            .q_out  (syn_w[gi])
         );
      end
   endgenerate

   assign dbg_w = syn_w[0];

   // ------------------------------------------------------------
   // Pin low-time qualifier
   // ------------------------------------------------------------
   // Glitches shorter than the minimum are ignored, so a board
   // that honours the 10 us low time always gets a reset.
   reg [15:0] pin_cnt_q;
   reg        pin_rst_q;

   always @(posedge clk_in) begin
      if (rst_in) begin
         pin_cnt_q <= 16'h0000;
         pin_rst_q <= 1'b0;
      end else if (pin_n_w) begin
         pin_cnt_q <= 16'h0000;
         pin_rst_q <= 1'b0;
      end else if (pin_cnt_q >= PIN_MIN_CYC[15:0] - 16'h0001) begin
         pin_rst_q <= 1'b1;
      end else begin
         pin_cnt_q <= pin_cnt_q + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // Illegal instruction detect
   // ------------------------------------------------------------
   reg ill_q;

   always @(posedge clk_in) begin
      if (rst_in)
         ill_q <= 1'b0;
      else if (sys_reset_out)
         ill_q <= 1'b0;
      else if (exec_valid_in && !dbg_w &&
               exec_opcode_in == `RSC_ILLEGAL_OP)
         ill_q <= 1'b1;
   end

   // ------------------------------------------------------------
   // Source combine
   // ------------------------------------------------------------
   reg  [`RSC_NSRC-1:0] src_w;
   always @* begin
      src_w = {`RSC_NSRC{1'b0}};
      src_w[`RSC_SRC_PIN] = pin_rst_q;
      src_w[`RSC_SRC_WDT] = syn_w[1];
      src_w[`RSC_SRC_POR] = syn_w[2];
      src_w[`RSC_SRC_LVD] = syn_w[3];
      src_w[`RSC_SRC_ILL] = ill_q;
      src_w[`RSC_SRC_PAR] = syn_w[4];
      src_w[`RSC_SRC_IMA] = syn_w[5];
   end

   wire any_src_w = |src_w;

   // ------------------------------------------------------------
   // Reset sequencer
   // ------------------------------------------------------------
   localparam ST_RUN  = 3'b001;
   localparam ST_HOLD = 3'b010;
   localparam ST_PROC = 3'b100;

   reg [2:0]  st_q;
   reg [15:0] proc_cnt_q;
   reg        float_q;
   reg        rout_hi_q;

   always @(posedge clk_in) begin
      if (rst_in) begin
         st_q        <= ST_HOLD;
         proc_cnt_q  <= 16'h0000;
         cause_out   <= {`RSC_NSRC{1'b0}};
         float_q     <= 1'b1;
         rout_hi_q   <= 1'b0;
         vector_fetch_out <= 1'b0;
      end else begin
         vector_fetch_out <= 1'b0;
         if (rout_set_high_in && st_q == ST_RUN)
            rout_hi_q <= 1'b1;
         case (st_q)
            ST_RUN: begin
               if (any_src_w) begin
                  st_q      <= ST_HOLD;
                  cause_out <= src_w;
                  rout_hi_q <= 1'b0;
                  float_q   <= src_w[`RSC_SRC_PIN] |
                               src_w[`RSC_SRC_POR];
               end
            end
            ST_HOLD: begin
               cause_out <= cause_out | src_w;
               rout_hi_q <= 1'b0;
               if (src_w[`RSC_SRC_PIN] | src_w[`RSC_SRC_POR])
                  float_q <= 1'b1;
               // The pin synchroniser resets to the asserted level, so hold
               // also spans its latency after rst_in and a pin held low.
               if (!any_src_w && pin_n_w) begin
                  st_q       <= ST_PROC;
                  proc_cnt_q <= 16'h0000;
               end
            end
            ST_PROC: begin
               float_q <= 1'b0;
               if (any_src_w)
                  st_q <= ST_HOLD;
               else if (proc_cnt_q >= PROC_CYC[15:0] - 16'h0001) begin
                  st_q             <= ST_RUN;
                  vector_fetch_out <= 1'b1;
               end else
                  proc_cnt_q <= proc_cnt_q + 16'h0001;
            end
            default: st_q <= ST_HOLD;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   // The voltage detector keeps its state when it caused the reset,
   // so its own reset comes only from the other sources.
   wire in_reset_w = (st_q != ST_RUN);

   always @(posedge clk_in) begin
      if (rst_in) begin
         sys_reset_out        <= 1'b1;
         wdt_reset_out        <= 1'b1;
         lvd_reset_out        <= 1'b1;
         sfr_init_out         <= 1'b1;
         vector_addr_out      <= `RSC_VEC_LO_ADDR;
         main_crystal_en_out  <= 1'b0;
         sub_crystal_en_out   <= 1'b0;
         fast_osc_en_out      <= 1'b0;
         slow_osc_en_out      <= 1'b0;
         clk_sel_fast_out     <= 1'b1;
         ext_main_clk_out     <= 1'b0;
         ext_sub_clk_out      <= 1'b0;
         pullup_port_pin_pu_out      <= 1'b0;
         reset_out_port_pin_out      <= 1'b0;
         reset_out_port_pin_oe_n_out <= 1'b0;
         port_oe_n_out        <= {NPORT{1'b1}};
      end else begin
         sys_reset_out   <= in_reset_w;
         sfr_init_out    <= st_q == ST_HOLD;
         wdt_reset_out   <= st_q == ST_HOLD;
         lvd_reset_out   <= (st_q == ST_HOLD) &&
                            !cause_out[`RSC_SRC_LVD] &&
                            !src_w[`RSC_SRC_LVD];
         vector_addr_out <= `RSC_VEC_LO_ADDR;
         main_crystal_en_out <= 1'b0;
         sub_crystal_en_out  <= 1'b0;
         slow_osc_en_out     <= !in_reset_w;
         fast_osc_en_out     <= st_q != ST_HOLD;
         clk_sel_fast_out    <= 1'b1;
         ext_main_clk_out <= !in_reset_w & ext_main_clk_in;
         ext_sub_clk_out  <= !in_reset_w & ext_sub_clk_in;
         pullup_port_pin_pu_out <= !(in_reset_w && float_q);
         reset_out_port_pin_out <= rout_hi_q & !in_reset_w;
         reset_out_port_pin_oe_n_out <= 1'b0;
         port_oe_n_out <= {NPORT{1'b1}};
      end
   end
endmodule // rsc_reset_ctrl

// File: dv/rsc_reset_ctrl_asserts.sv
// Purpose: Port checks for the reset source controller.
// Assumes: One clock domain on clk_in with synchronous rst_in.
// Notes:   Bound into every rsc_reset_ctrl instance.
`timescale 1ns/1ps
`include "rsc_regs.vh"
module rsc_chk #(
   parameter NPORT = 8
) (
   // Clock, reset and software input
   input wire logic                 clk_in,
   input wire logic                 rst_in,
   input wire logic                 rout_set_high_in,
   // Watched outputs
   input wire logic                 sys_reset_out,
   input wire logic                 wdt_reset_out,
   input wire logic                 lvd_reset_out,
   input wire logic                 sfr_init_out,
   input wire logic [15:0]          vector_addr_out,
   input wire logic                 vector_fetch_out,
   input wire logic [`RSC_NSRC-1:0] cause_out,
   input wire logic                 main_crystal_en_out,
   input wire logic                 sub_crystal_en_out,
   input wire logic                 fast_osc_en_out,
   input wire logic                 slow_osc_en_out,
   input wire logic                 clk_sel_fast_out,
   input wire logic                 ext_main_clk_out,
   input wire logic                 ext_sub_clk_out,
   input wire logic                 pullup_port_pin_pu_out,
   input wire logic                 reset_out_port_pin_out,
   input wire logic                 reset_out_port_pin_oe_n_out,
   input wire logic [NPORT-1:0]     port_oe_n_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence s_hold2;
      wdt_reset_out ##1 wdt_reset_out;
   endsequence
   sequence s_exit;
      vector_fetch_out ##1 !sys_reset_out;
   endsequence
   property p_osc;
      wdt_reset_out |-> !(main_crystal_en_out | sub_crystal_en_out
         | fast_osc_en_out | slow_osc_en_out);
   endproperty
   property p_ext;
      sys_reset_out && $past(sys_reset_out)
         |-> !ext_main_clk_out && !ext_sub_clk_out;
   endproperty
   property p_init;
      sfr_init_out |-> wdt_reset_out && sys_reset_out;
   endproperty
   property p_vec;
      $fell(sys_reset_out)
         |-> $past(vector_fetch_out) && $past(vector_addr_out) == 16'h0000;
   endproperty
   property p_run;
      s_exit |-> fast_osc_en_out && clk_sel_fast_out;
   endproperty
   property p_pu;
      !sys_reset_out ##1 s_hold2 ##0 !cause_out[0] && !cause_out[2]
         |-> pullup_port_pin_pu_out;
   endproperty
   property p_lvd;
      s_hold2 ##0 !cause_out[3] |-> lvd_reset_out;
   endproperty
   property p_rout;
      sys_reset_out
         |-> !reset_out_port_pin_out && !reset_out_port_pin_oe_n_out;
   endproperty
   property p_rhold;
      $past(!reset_out_port_pin_out) && !$past(rout_set_high_in, 2)
         |-> !reset_out_port_pin_out;
   endproperty
   property p_port;
      port_oe_n_out == {NPORT{1'b1}};
   endproperty
   a_osc: assert property (p_osc) else $error("osc on in hold");
   a_ext: assert property (p_ext) else $error("ext clk passed");
   a_init: assert property (p_init) else $error("init outside");
   a_vec: assert property (p_vec) else $error("bad vector exit");
   a_run: assert property (p_run) else $error("not fast clock");
   a_pu: assert property (p_pu) else $error("pull-up missing");
   a_lvd: assert property (p_lvd) else $error("detector held");
   a_rout: assert property (p_rout) else $error("rout not low");
   a_rhold: assert property (p_rhold) else $error("rout rose");
   a_port: assert property (p_port) else $error("port driven");
endmodule // rsc_chk
bind rsc_reset_ctrl rsc_chk #(.NPORT(NPORT)) u_chk (.clk_in(clk_in),
   .rst_in(rst_in), .rout_set_high_in(rout_set_high_in),
   .sys_reset_out(sys_reset_out), .wdt_reset_out(wdt_reset_out),
   .lvd_reset_out(lvd_reset_out), .sfr_init_out(sfr_init_out),
   .vector_addr_out(vector_addr_out), .cause_out(cause_out),
   .vector_fetch_out(vector_fetch_out),
   .main_crystal_en_out(main_crystal_en_out),
   .sub_crystal_en_out(sub_crystal_en_out),
   .fast_osc_en_out(fast_osc_en_out), .slow_osc_en_out(slow_osc_en_out),
   .clk_sel_fast_out(clk_sel_fast_out),
   .ext_main_clk_out(ext_main_clk_out), .ext_sub_clk_out(ext_sub_clk_out),
   .pullup_port_pin_pu_out(pullup_port_pin_pu_out),
   .reset_out_port_pin_out(reset_out_port_pin_out),
   .reset_out_port_pin_oe_n_out(reset_out_port_pin_oe_n_out),
   .port_oe_n_out(port_oe_n_out));

// File: dv/rsc_supervisor.sv
// Purpose: Board supervisor that drives the reset pin.
// Assumes: Requests arrive on clk_in from the bench.
// Notes:   Short requests exist to test refusal of glitches.
`timescale 1ns/1ps
module rsc_supervisor #(
   parameter PWR_LOW_CYC = 30
) (
   // Clock and request
   input  wire logic        clk_in,
   input  wire logic        start_in,
   input  wire logic [15:0] low_cyc_in,
   // Reset pin
   output wire logic        reset_pin_n_out
);
   // Low from time zero: the pin is held before the supply is good.
   logic [15:0] cnt_q = PWR_LOW_CYC[15:0];
   assign reset_pin_n_out = (cnt_q == 16'h0000);
   always @(posedge clk_in) begin
      if (start_in) begin
         cnt_q <= low_cyc_in;
      end else if (cnt_q != 16'h0000) begin
         cnt_q <= cnt_q - 16'h0001;
      end
   end
endmodule // rsc_supervisor

// File: dv/testbench.sv
// Purpose: Self-checking bench for the reset source controller.
// Assumes: Pin minimum shortened to 4 cycles, processing to 2.
// Notes:   Each row resets the block first, as cause bits are sticky.
`timescale 1ns/1ps
module testbench;
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic [4:0]  src    = 5'h00;
   logic        xv     = 1'b0;
   logic        dbg    = 1'b0;
   logic [7:0]  op     = 8'hff;
   logic        rset   = 1'b0;
   logic        sv_go  = 1'b0;
   logic [15:0] sv_low = 16'h0000;
   wire         pin_n, sr, hold, lvdr, pu, rout, emc, esc;
   wire  [6:0]  cause;
   int          fail_count = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          r;
   // Row: expected reset, pull-up, detector reset, cause bits.
   localparam logic [9:0] ROWS [9] = '{10'h382, 10'h284, 10'h308,
      10'h3a0, 10'h3c0, 10'h390, 10'h180, 10'h281, 10'h180};
   rsc_supervisor sv (.clk_in(clk_in), .start_in(sv_go),
      .low_cyc_in(sv_low), .reset_pin_n_out(pin_n));
   rsc_reset_ctrl #(.PIN_MIN_CYC(4), .PROC_CYC(2)) dut (.clk_in(clk_in),
      .rst_in(rst_in), .reset_pin_n_in(pin_n), .wdt_overflow_in(src[0]),
      .por_detect_in(src[1]), .lvd_detect_in(src[2]),
      .parity_err_in(src[3]), .illegal_access_in(src[4]),
      .exec_valid_in(xv), .exec_opcode_in(op), .debug_mode_in(dbg),
      .rout_set_high_in(rset), .ext_main_clk_in(1'b1),
      .ext_sub_clk_in(1'b1), .sys_reset_out(sr), .wdt_reset_out(hold),
      .lvd_reset_out(lvdr), .sfr_init_out(), .vector_addr_out(),
      .vector_fetch_out(), .cause_out(cause), .main_crystal_en_out(),
      .sub_crystal_en_out(), .fast_osc_en_out(), .slow_osc_en_out(),
      .clk_sel_fast_out(), .ext_main_clk_out(emc),
      .ext_sub_clk_out(esc), .pullup_port_pin_pu_out(pu),
      .reset_out_port_pin_out(rout), .reset_out_port_pin_oe_n_out(),
      .port_oe_n_out());
   always #4 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 4000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic chk(input string what, input logic [9:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   // Bounded waits keep a stuck design from hanging the run.
   task automatic run_out();
      for (int i = 0; i < 60 && sr !== 1'b0; i++) tick(1);
   endtask
   task automatic to_hold();
      for (int i = 0; i < 20 && hold !== 1'b1; i++) tick(1);
   endtask
   task automatic do_rst();
      rst_in = 1'b1;
      tick(2);
      rst_in = 1'b0;
      run_out();
   endtask
   task final_report();
      if (fail_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      tick(16);
      rst_in = 1'b0;
      run_out();
      chk("power-up cause", 10'h001, {3'h0, cause});
      for (r = 0; r < 9; r++) begin
         dbg = (r == 6);
         do_rst();
         if (r < 5) src[r] = 1'b1;
         else if (r < 7) begin
            xv = 1'b1;
            tick(1);
            xv = 1'b0;
         end else begin
            sv_low = (r == 7) ? 16'h0008 : 16'h0002;
            sv_go = 1'b1;
            tick(1);
            sv_go = 1'b0;
         end
         to_hold();
         tick(2);
         chk("reset", ROWS[r][9], sr);
         chk("cause", ROWS[r][6:0], cause);
         if (ROWS[r][9]) begin
            chk("pull-up", ROWS[r][8], pu);
            chk("detector", ROWS[r][7], lvdr);
            chk("ext clk", 10'h000, {emc, esc});
         end
         src = 5'h00;
         run_out();
      end
      do_rst();
      op = 8'hfe;
      xv = 1'b1;
      tick(1);
      xv = 1'b0;
      op = 8'hff;
      tick(8);
      chk("legal opcode", 10'h000, sr);
      do_rst();
      src = 5'h09;
      tick(10);
      src[0] = 1'b0;
      tick(20);
      chk("held", 10'h001, sr);
      src = 5'h00;
      run_out();
      chk("released", 10'h022, {sr, cause});
      chk("ext run", 10'h003, {emc, esc});
      chk("rout low", 10'h000, rout);
      rset = 1'b1;
      tick(1);
      rset = 1'b0;
      tick(1);
      chk("rout set", 10'h001, rout);
      src[0] = 1'b1;
      to_hold();
      chk("rout reset", 10'h000, rout);
      src = 5'h00;
      run_out();
      final_report();
   end
endmodule // testbench
